// >>> design/gpmx_pkg.sv
`default_nettype none
package gpmx_pkg;
  // Register byte offsets.
  localparam logic [7:0] GPMX_OFF_P4_DATA = 8'h00;
  localparam logic [7:0] GPMX_OFF_P4_DIR = 8'h04;
  localparam logic [7:0] GPMX_OFF_P4_FSEL = 8'h08;
  localparam logic [7:0] GPMX_OFF_P5_DATA = 8'h0C;
  localparam logic [7:0] GPMX_OFF_P5_DIR = 8'h10;
  localparam logic [7:0] GPMX_OFF_SER_CTRL = 8'h14;
  // Port 4 pin count and field positions.
  localparam int GPMX_P4_PINS = 3;
  localparam int GPMX_FSEL_TIMER_EVT = 0;
  localparam int GPMX_FSEL_TIMER_LO = 1;
  localparam int GPMX_FSEL_TIMER_HI = 2;
  localparam int GPMX_SC_CLK_LO = 0;
  localparam int GPMX_SC_CLK_HI = 1;
  localparam int GPMX_SC_SYNC = 2;
  localparam int GPMX_SC_TX_PIN_EN = 3;
  localparam int GPMX_SC_RX_EN = 4;
  localparam int GPMX_SC_IR_EN = 5;
  // Reset values, reserved read bits and response codes.
  localparam logic [2:0] GPMX_RST_P4 = 3'h0;
  localparam logic [7:0] GPMX_RST_P5 = 8'h00;
  localparam logic [5:0] GPMX_RST_SC = 6'h00;
  localparam logic [4:0] GPMX_RSVD_ONES = 5'h1F;
  localparam logic [1:0] GPMX_RESP_OKAY = 2'h0;
  localparam logic [1:0] GPMX_RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// >>> design/gpmx_sync_if.sv
`default_nettype none
interface gpmx_sync_if;
  logic [10:0] raw;
  logic [10:0] clean;
  modport src (output raw, input clean);
  modport snk (input raw, output clean);
endinterface
`default_nettype wire

// >>> design/gpmx_sync.sv
`default_nettype none
module gpmx_sync (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Pin levels in, filtered levels out
  gpmx_sync_if.snk sif
);
  logic [10:0] s1;
  logic [10:0] s2;
  logic [10:0] s3;
  logic [10:0] held;

  // A change is accepted only once stages two and three agree.
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      s1 <= 11'h000;
      s2 <= 11'h000;
      s3 <= 11'h000;
      held <= 11'h000;
    end else begin
      s1 <= sif.raw;
      s2 <= s1;
      s3 <= s2;
      held <= (s2 & s3) | (held & (s2 | s3));
    end
  end

  assign sif.clean = held;
endmodule
`default_nettype wire

// >>> design/gpmx_top.sv
`default_nettype none
module gpmx_top (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // AXI4-Lite write address
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  // AXI4-Lite write data
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // AXI4-Lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read address
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  // AXI4-Lite read data
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Port 4 pins
  input wire logic [2:0] i_p4_pin,
  output logic [2:0] o_p4_pin,
  output logic [2:0] o_p4_pin_oe,
  // Port 5 pins
  input wire logic [7:0] i_p5_pin,
  output logic [7:0] o_p5_pin,
  output logic [7:0] o_p5_pin_oe,
  // Serial channel, timer and port 5 wakeup
  input wire logic i_serial_transmit_line,
  input wire logic i_infrared_transmit_line,
  input wire logic i_serial_clock_line,
  input wire logic i_timer_high_compare_out,
  input wire logic i_timer_low_compare_out,
  output logic o_serial_receive_line,
  output logic o_infrared_receive_line,
  output logic o_serial_clock_line,
  output logic o_timer_event_in,
  output logic [7:0] o_wakeup
);
  import gpmx_pkg::*;

  // ****************************************
  // Register state
  // ****************************************
  logic [2:0] port4_pin_data;
  logic [2:0] port4_direction;
  logic [2:0] port4_function_select;
  logic [7:0] port5_pin_data;
  logic [7:0] port5_direction;
  logic [5:0] serial_port_control_reg;

  gpmx_sync_if sif ();
  gpmx_sync u_sync (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .sif(sif)
  );
  assign sif.raw = {i_p5_pin, i_p4_pin};
  wire [2:0] p4_in = sif.clean[2:0];
  wire [7:0] p5_in = sif.clean[10:3];

  // ****************************************
  // Pin multiplexing
  // ****************************************
  wire clk_src_bit_lo = serial_port_control_reg[GPMX_SC_CLK_LO];
  wire clk_src_bit_hi = serial_port_control_reg[GPMX_SC_CLK_HI];
  wire sync_mode = serial_port_control_reg[GPMX_SC_SYNC];
  wire serial_tx_pin_enable = serial_port_control_reg[GPMX_SC_TX_PIN_EN];
  wire rx_enable = serial_port_control_reg[GPMX_SC_RX_EN];
  wire infrared_enable = serial_port_control_reg[GPMX_SC_IR_EN];
  wire sel_timer_hi = port4_function_select[GPMX_FSEL_TIMER_HI];
  wire sel_timer_lo = port4_function_select[GPMX_FSEL_TIMER_LO];
  wire sel_timer_evt = port4_function_select[GPMX_FSEL_TIMER_EVT];

  // Pin 2 priority chain.
  wire tx_line = infrared_enable ? i_infrared_transmit_line : i_serial_transmit_line;
  wire next_p4_oe2 = sel_timer_hi | serial_tx_pin_enable | port4_direction[2];
  wire next_p4_out2 = sel_timer_hi ? i_timer_high_compare_out :
                      serial_tx_pin_enable ? tx_line : port4_pin_data[2];

  // Pin 1 priority chain.
  wire p1_gpio = !sel_timer_lo && !rx_enable;
  wire next_p4_oe1 = sel_timer_lo | (p1_gpio & port4_direction[1]);
  wire next_p4_out1 = sel_timer_lo ? i_timer_low_compare_out : port4_pin_data[1];
  wire rx_route = !sel_timer_lo && rx_enable;

  // Pin 0 priority chain; the prohibited clock setting keeps the driver off.
  wire clk_bad = clk_src_bit_hi & clk_src_bit_lo;
  wire p0_gpio = !sel_timer_evt && !clk_src_bit_hi && !clk_src_bit_lo && !sync_mode;
  wire p0_sck_out = !sel_timer_evt && !clk_bad &&
                    ((!clk_src_bit_hi && sync_mode) || clk_src_bit_lo);
  wire p0_sck_in = !sel_timer_evt && clk_src_bit_hi && !clk_src_bit_lo;
  wire next_p4_oe0 = p0_sck_out | (p0_gpio & port4_direction[0]);
  wire next_p4_out0 = p0_sck_out ? i_serial_clock_line : port4_pin_data[0];

  // Port 5 stays general I/O; o_wakeup follows all eight filtered port 5 levels.
  wire [7:0] next_p5_oe = port5_direction;

  // ****************************************
  // Bus decode
  // ****************************************
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
    addr_hit = (a[7:2] == off[7:2]);
  endfunction

  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [7:0] w_data;
  logic w_lane0;
  wire [7:0] wr_addr = aw_held ? aw_addr : i_awaddr;
  wire [7:0] wr_data = w_held ? w_data : i_wdata[7:0];
  wire wr_lane0 = w_held ? w_lane0 : i_wstrb[0];
  wire aw_ok = aw_held | i_awvalid;
  wire w_ok = w_held | i_wvalid;
  wire wr_go = aw_ok && w_ok && !o_bvalid;
  wire wr_en = wr_go && wr_lane0;
  wire wr_known = addr_hit(wr_addr, GPMX_OFF_P4_DATA) | addr_hit(wr_addr, GPMX_OFF_P4_DIR) |
                  addr_hit(wr_addr, GPMX_OFF_P4_FSEL) | addr_hit(wr_addr, GPMX_OFF_P5_DATA) |
                  addr_hit(wr_addr, GPMX_OFF_P5_DIR) | addr_hit(wr_addr, GPMX_OFF_SER_CTRL);

  wire [2:0] p4_read = (port4_direction & port4_pin_data) | (~port4_direction & p4_in);
  wire [7:0] p5_read = (port5_direction & port5_pin_data) | (~port5_direction & p5_in);
  wire [7:0] rd_addr = i_araddr;
  wire [7:0] rd_val = addr_hit(rd_addr, GPMX_OFF_P4_DATA) ? {GPMX_RSVD_ONES, p4_read} :
                      addr_hit(rd_addr, GPMX_OFF_P4_DIR) ? 8'hFF :
                      addr_hit(rd_addr, GPMX_OFF_P4_FSEL) ?
                        {GPMX_RSVD_ONES, port4_function_select} :
                      addr_hit(rd_addr, GPMX_OFF_P5_DATA) ? p5_read :
                      addr_hit(rd_addr, GPMX_OFF_P5_DIR) ? 8'hFF :
                      addr_hit(rd_addr, GPMX_OFF_SER_CTRL) ? {2'h0, serial_port_control_reg} :
                      8'h00;
  wire rd_known = addr_hit(rd_addr, GPMX_OFF_P4_DATA) | addr_hit(rd_addr, GPMX_OFF_P4_DIR) |
                  addr_hit(rd_addr, GPMX_OFF_P4_FSEL) | addr_hit(rd_addr, GPMX_OFF_P5_DATA) |
                  addr_hit(rd_addr, GPMX_OFF_P5_DIR) | addr_hit(rd_addr, GPMX_OFF_SER_CTRL);
  wire rd_go = i_arvalid && o_arready;

  // ****************************************
  // Write channel
  // ****************************************
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= GPMX_RESP_OKAY;
    end else begin
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= wr_known ? GPMX_RESP_OKAY : GPMX_RESP_SLVERR;
      end else begin
        if (i_awvalid && !aw_held && !o_awready) begin
          aw_held <= 1'b1;
          aw_addr <= i_awaddr;
        end
        if (i_wvalid && !w_held && !o_wready) begin
          w_held <= 1'b1;
          w_data <= i_wdata[7:0];
          w_lane0 <= i_wstrb[0];
        end
        if (o_bvalid && i_bready) begin
          o_bvalid <= 1'b0;
        end
      end
      if (i_awvalid && !aw_held && !o_awready && !o_bvalid) begin
        o_awready <= 1'b1;
      end
      if (i_wvalid && !w_held && !o_wready && !o_bvalid) begin
        o_wready <= 1'b1;
      end
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      port4_pin_data <= GPMX_RST_P4;
      port4_direction <= GPMX_RST_P4;
      port4_function_select <= GPMX_RST_P4;
      port5_pin_data <= GPMX_RST_P5;
      port5_direction <= GPMX_RST_P5;
      serial_port_control_reg <= GPMX_RST_SC;
    end else if (wr_en) begin
      if (addr_hit(wr_addr, GPMX_OFF_P4_DATA)) begin
        port4_pin_data <= wr_data[2:0];
      end
      if (addr_hit(wr_addr, GPMX_OFF_P4_DIR)) begin
        port4_direction <= wr_data[2:0];
      end
      if (addr_hit(wr_addr, GPMX_OFF_P4_FSEL)) begin
        port4_function_select <= wr_data[2:0];
      end
      if (addr_hit(wr_addr, GPMX_OFF_P5_DATA)) begin
        port5_pin_data <= wr_data;
      end
      if (addr_hit(wr_addr, GPMX_OFF_P5_DIR)) begin
        port5_direction <= wr_data;
      end
      if (addr_hit(wr_addr, GPMX_OFF_SER_CTRL)) begin
        serial_port_control_reg <= wr_data[5:0];
      end
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= GPMX_RESP_OKAY;
    end else begin
      o_arready <= i_arvalid && !o_arready && !o_rvalid;
      if (rd_go) begin
        o_rvalid <= 1'b1;
        o_rdata <= {24'h000000, rd_val};
        o_rresp <= rd_known ? GPMX_RESP_OKAY : GPMX_RESP_SLVERR;
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Registered pin and peripheral outputs
  // ****************************************
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_p4_pin <= 3'h0;
      o_p4_pin_oe <= 3'h0;
      o_p5_pin <= 8'h00;
      o_p5_pin_oe <= 8'h00;
      o_serial_receive_line <= 1'b1;
      o_infrared_receive_line <= 1'b1;
      o_serial_clock_line <= 1'b0;
      o_timer_event_in <= 1'b0;
      o_wakeup <= 8'h00;
    end else begin
      o_p4_pin <= {next_p4_out2, next_p4_out1, next_p4_out0};
      o_p4_pin_oe <= {next_p4_oe2, next_p4_oe1, next_p4_oe0};
      o_p5_pin <= port5_pin_data;
      o_p5_pin_oe <= next_p5_oe;
      // Idle receivers see a mark level while the pin is not theirs.
      o_serial_receive_line <= (rx_route && !infrared_enable) ? p4_in[1] : 1'b1;
      o_infrared_receive_line <= (rx_route && infrared_enable) ? p4_in[1] : 1'b1;
      o_serial_clock_line <= p0_sck_in ? p4_in[0] : 1'b0;
      o_timer_event_in <= sel_timer_evt ? p4_in[0] : 1'b0;
      o_wakeup <= p5_in;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/gpmx_pins_model.sv
`default_nettype none
module gpmx_pins_model (
  // Device side
  input wire logic [2:0] i_p4_out,
  input wire logic [2:0] i_p4_oe,
  input wire logic [7:0] i_p5_out,
  input wire logic [7:0] i_p5_oe,
  // Outside levels and resolved pins
  input wire logic [2:0] i_p4_ext,
  input wire logic [7:0] i_p5_ext,
  output logic [2:0] o_p4_lvl,
  output logic [7:0] o_p5_lvl
);
  timeunit 1ns;
  timeprecision 100ps;
  // An idle pin shows the outside level, so a stuck enable shows up in reads.
  assign o_p4_lvl = (i_p4_oe & i_p4_out) | (~i_p4_oe & i_p4_ext);
  assign o_p5_lvl = (i_p5_oe & i_p5_out) | (~i_p5_oe & i_p5_ext);
endmodule
`default_nettype wire

// >>> testbench/gpmx_top_properties.sv
`default_nettype none
module gpmx_props
  import gpmx_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_arvalid,
  input wire logic [7:0] i_araddr,
  input wire logic i_bready,
  input wire logic i_rready,
  input wire logic [7:0] i_p5_pin,
  input wire logic o_awready,
  input wire logic o_bvalid,
  input wire logic [1:0] o_bresp,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic [2:0] o_p4_pin_oe,
  input wire logic o_serial_receive_line,
  input wire logic o_serial_clock_line,
  input wire logic o_timer_event_in,
  input wire logic [7:0] o_wakeup
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] ar_q;
  always_ff @(posedge i_core_clk) begin
    if (i_arvalid && o_arready) begin
      ar_q <= i_araddr;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  property p_aw_pulse; o_awready |=> !o_awready; endproperty
  a_aw_pulse: assert property (p_aw_pulse) else $error("awready longer than one cycle");
  property p_bhold; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_rfollow; i_arvalid && o_arready |=> o_rvalid; endproperty
  a_rfollow: assert property (p_rfollow) else $error("read data late");
  property p_dir; o_rvalid && ar_q == GPMX_OFF_P4_DIR |-> o_rdata == 32'h000000FF; endproperty
  a_dir: assert property (p_dir) else $error("direction read not ones");
  property p_rsvd; o_rvalid && ar_q == GPMX_OFF_P4_FSEL |-> o_rdata[7:3] == 5'h1F; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not one");
  property p_unmap;
    o_rvalid && ar_q[7:2] > GPMX_OFF_SER_CTRL[7:2] |-> o_rresp == 2'h2;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
  property p_evt; o_timer_event_in && $past(o_timer_event_in) |-> !o_p4_pin_oe[0]; endproperty
  a_evt: assert property (p_evt) else $error("event pin driven");
  property p_rx; !o_serial_receive_line && $past(!o_serial_receive_line) |-> !o_p4_pin_oe[1];
  endproperty
  a_rx: assert property (p_rx) else $error("receive pin driven");
  property p_ck; o_serial_clock_line && $past(o_serial_clock_line) |-> !o_p4_pin_oe[0]; endproperty
  a_ck: assert property (p_ck) else $error("clock input pin driven");
  property p_wake; $stable(i_p5_pin)[*8] |-> o_wakeup == i_p5_pin; endproperty
  a_wake: assert property (p_wake) else $error("wakeup not following pins");
endmodule
bind gpmx_top gpmx_props i_props (.i_core_clk, .i_resetn, .i_arvalid, .i_araddr, .i_bready,
  .i_rready, .i_p5_pin, .o_awready, .o_bvalid, .o_bresp, .o_arready, .o_rvalid, .o_rdata,
  .o_rresp, .o_p4_pin_oe, .o_serial_receive_line, .o_serial_clock_line, .o_timer_event_in,
  .o_wakeup);
`default_nettype wire

// >>> testbench/gpmx_tb_top.sv
`default_nettype none
module gpmx_tb_top;
  import gpmx_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_core_clk = 0, i_resetn = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
  logic i_arvalid = 0, i_rready = 0, stx = 0, irtx = 0, scko = 0, thi = 0, tlo = 0;
  logic [7:0] i_awaddr = 0, i_araddr = 0, p5_ext = 0, i_p5_pin, o_p5_pin, o_p5_pin_oe, o_wakeup;
  logic [31:0] i_wdata = 0, o_rdata, rv;
  logic [3:0] i_wstrb = 0;
  logic [2:0] p4_ext = 0, i_p4_pin, o_p4_pin, o_p4_pin_oe, f, eo, ev, lv;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, srx, irx, scki, tev, sco;
  logic [1:0] o_bresp, o_rresp, rr, br;
  logic [7:0] d, m, e;
  logic [5:0] s;
  int n_mismatch = 0, n_tests = 0;
  always #2 i_core_clk = ~i_core_clk;
  gpmx_top i_dut (.i_core_clk, .i_resetn, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid,
    .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready,
    .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp, .i_p4_pin, .o_p4_pin, .o_p4_pin_oe,
    .i_p5_pin, .o_p5_pin, .o_p5_pin_oe, .i_serial_transmit_line(stx),
    .i_infrared_transmit_line(irtx), .i_serial_clock_line(scko),
    .i_timer_high_compare_out(thi), .i_timer_low_compare_out(tlo),
    .o_serial_receive_line(srx), .o_infrared_receive_line(irx),
    .o_serial_clock_line(scki), .o_timer_event_in(tev), .o_wakeup);
  gpmx_pins_model i_pins (.i_p4_out(o_p4_pin), .i_p4_oe(o_p4_pin_oe), .i_p5_out(o_p5_pin),
    .i_p5_oe(o_p5_pin_oe), .i_p4_ext(p4_ext), .i_p5_ext(p5_ext), .o_p4_lvl(i_p4_pin),
    .o_p5_lvl(i_p5_pin));
  // ********
  // Bus tasks
  // ********
  task automatic test_done;
    $display("Tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int k);
    if (k >= 50) begin
      n_mismatch++;
      $display("Error %0t bus timeout", $time);
      test_done();
    end
  endtask
  // Ready is raised only after the answer, so the slave must hold it meanwhile.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    int k;
    k = 0;
    i_awvalid <= 1;
    i_awaddr <= a;
    i_wvalid <= 1;
    i_wdata <= {24'h0, v};
    i_wstrb <= 4'hF;
    do begin
      @(posedge i_core_clk);
      if (o_awready) i_awvalid <= 0;
      if (o_wready) i_wvalid <= 0;
      k++;
    end while (!o_bvalid && k < 50);
    tmo(k);
    br = o_bresp;
    i_bready <= 1;
    @(posedge i_core_clk);
    i_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    int k;
    k = 0;
    i_arvalid <= 1;
    i_araddr <= a;
    do begin
      @(posedge i_core_clk);
      if (o_arready) i_arvalid <= 0;
      k++;
    end while (!o_rvalid && k < 50);
    tmo(k);
    i_rready <= 1;
    @(posedge i_core_clk);
    rv = o_rdata;
    rr = o_rresp;
    i_rready <= 0;
  endtask
  initial begin
    void'($urandom(15));
    repeat (6) @(posedge i_core_clk);
    i_resetn <= 1;
    rd(GPMX_OFF_P4_DIR);
    chk(rv, 32'hFF);
    wr(GPMX_OFF_P4_FSEL, 8'h02);
    chk({30'h0, br}, {30'h0, GPMX_RESP_OKAY});
    rd(GPMX_OFF_P4_FSEL);
    chk(rv, 32'hFA);
    chk({30'h0, rr}, {30'h0, GPMX_RESP_OKAY});
    wr(GPMX_OFF_P4_FSEL, 8'h00);
    wr(GPMX_OFF_P5_DIR, 8'hFF);
    rd(GPMX_OFF_P5_DATA);
    chk(rv, 32'h0);
    rd(8'h40);
    chk({30'h0, rr}, {30'h0, GPMX_RESP_SLVERR});
    chk(rv, 32'h0);
    wr(8'h40, 8'h55);
    chk({30'h0, br}, {30'h0, GPMX_RESP_SLVERR});
    $display("Test registers done");
    for (int k = 0; k < 12; k++) begin
      d = 8'($urandom);
      m = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($urandom);
      p4_ext <= 3'($urandom);
      p5_ext <= 8'($urandom);
      wr(GPMX_OFF_P5_DATA, d);
      wr(GPMX_OFF_P5_DIR, m);
      wr(GPMX_OFF_P4_DATA, d);
      wr(GPMX_OFF_P4_DIR, m);
      repeat (8) @(posedge i_core_clk);
      e = (d & m) | (p5_ext & ~m);
      rd(GPMX_OFF_P5_DATA);
      chk(rv, {24'h0, e});
      chk({24'h0, o_wakeup}, {24'h0, e});
      lv = (d[2:0] & m[2:0]) | (p4_ext & ~m[2:0]);
      rd(GPMX_OFF_P4_DATA);
      chk(rv, {24'h0, 5'h1F, lv});
      chk({29'h0, o_p4_pin_oe}, {29'h0, m[2:0]});
    end
    $display("Test data done");
    for (int k = 0; k < 40; k++) begin
      f = (k == 0) ? 3'h0 : 3'($urandom);
      s = (k == 0) ? 6'h03 : 6'($urandom);
      if (k != 0 && s[1:0] == 2'h3) s[0] = 0;
      d = 8'($urandom);
      m = 8'($urandom);
      {stx, irtx, scko, thi, tlo} <= 5'($urandom);
      p4_ext <= 3'($urandom);
      wr(GPMX_OFF_P4_DATA, d);
      wr(GPMX_OFF_P4_DIR, m);
      wr(GPMX_OFF_P4_FSEL, {5'h0, f});
      wr(GPMX_OFF_SER_CTRL, {2'h0, s});
      repeat (8) @(posedge i_core_clk);
      sco = !f[0] && !s[1] && (s[2] || s[0]);
      eo = {f[2] | s[3] | m[2], f[1] | (!s[4] & m[1]),
        sco | (!f[0] && s[2:0] == 3'h0 && m[0])};
      ev = {f[2] ? thi : s[3] ? (s[5] ? irtx : stx) : d[2], f[1] ? tlo : d[1], sco ? scko : d[0]};
      lv = (eo & ev) | (~eo & p4_ext);
      chk({22'h0, o_p4_pin_oe, o_p4_pin & eo, srx, irx, tev, scki},
        {22'h0, eo, ev & eo, (!f[1] && s[4] && !s[5]) ? lv[1] : 1'b1,
        (!f[1] && s[4] && s[5]) ? lv[1] : 1'b1, f[0] & lv[0],
        (!f[0] && s[1:0] == 2'h2) & lv[0]});
    end
    $display("Test pin functions done");
    test_done();
  end
endmodule
`default_nettype wire
